//--- pkg/csd_pkg.sv
/*
 * Shared constants and carriers for the control store read path:
 * address field positions, delay-line tap positions and cycle timing.
 * Assumes a single 10 MHz reference clock drives the whole block.
 */
package csd_pkg;

   // Reference clock and cycle timing
   localparam int CLK_PERIOD_NS   = 100;
   localparam int CYCLE_NS        = 500;
   localparam int SENSE_DELAY_NS  = 100;
   localparam int CYCLE_CLKS      = CYCLE_NS / CLK_PERIOD_NS;
   // Least time: round up, at least one cycle
   localparam int SENSE_DLY_CLKS  = (SENSE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Delay-line tap positions within one cycle
   localparam int TAP_RESTORE     = 0;
   localparam int TAP_GATE        = 1;
   localparam int TAP_DRIVE       = 2;
   localparam int TAP_SENSE       = TAP_DRIVE + SENSE_DLY_CLKS;
   localparam int TAP_SUPPLY_OFF  = TAP_SENSE + 1;
   localparam int TAP_LEN         = CYCLE_CLKS;

   // Address layout
   localparam int ADDR_W          = 12;
   localparam int GATE_MSB        = 11;
   localparam int GATE_NUM_MSB    = 10;
   localparam int GATE_LSB        = 6;
   localparam int MODULE_MSB      = 10;
   localparam int MODULE_LSB      = 8;
   localparam int UPPER_HALF_BIT  = 7;
   localparam int WORD_HALF_BIT   = 6;
   localparam int DRV_MSB         = 5;
   localparam int DRV_HI_LSB      = 3;
   localparam int DRV_LO_MSB      = 2;

   // Selection matrix and word
   localparam int NUM_GATES       = 32;
   localparam int NUM_DRIVERS     = 64;
   localparam int OCTAL_LINES     = 8;
   localparam int WORD_W          = 48;
   localparam logic [6:0] TAPE_MAX = 7'h7f;
   localparam logic [47:0] WORD_RST = 48'h0;

   typedef struct packed {
      logic       spare_bit;
      logic [2:0] module_num;
      logic [1:0] local_gate;
      logic [2:0] drv_hi;
      logic [2:0] drv_lo;
   } csd_addr_s;

   typedef struct packed {
      logic sense_restore;
      logic gate_strobe;
      logic drv_supply;
      logic drv_strobe;
      logic array_current;
      logic sense_reset;
      logic sense_strobe;
   } csd_strobe_s;

endpackage : csd_pkg

//--- rtl/csd_read_path.sv
/*
 * Control store read path: address decode, delay-line timing and sense latches.
 * Assumes the sequencer, the inhibit source and the sense amplifiers all run on
 * i_ref_clk, so their signals need no synchroniser.
 */
// What this block does
// - Gate selection from address bits 10-6 (bit 11 unused), driver selection from bits 5-0.
// - Address bits 10-6 as unsigned value give the global gate number.
// - Bits 10-8 module, bits 7-6 local gate; gate equals module*4 plus local.
// - Address bits 5-0 as unsigned value give the driver number.
// - Driver low octal from bits 2-0, high octal from 5-3; lines intersect.
// - Upper-half bit set: tape is 127 minus driver; clear: tape equals driver.
// - Word-half bit picks second word via odd local gate when set.
// - One read every 500 ns, continuous; one pulse, delayed taps make strobes.
// - Sense restore first; gate and driver decode during restore.
// - Gate strobe turns on decoded gate before driver; no early current.
// - Driver supply on with gate; later driver strobe starts word current.
// - Sense strobe about 100 ns after current; reset latches capture 48 bits.
// - Driver supply switched off after sense strobe captures the word.
// - Inhibit suppresses sense reset and strobe; latches hold last word.
// - 32 gates, 64 drivers; exactly one of each active per word.
`timescale 1ns/10ps

module csd_onehot_dec #(
   parameter int IN_W = 3
) (
   input  wire logic [IN_W-1:0]       i_sel,    // Binary select
   input  wire logic                  i_en,     // Enable
   output logic      [(1<<IN_W)-1:0]  o_lines   // One-hot lines
);
   assign o_lines = i_en ? ((1 << IN_W)'(1) << i_sel) : '0;
endmodule : csd_onehot_dec

module csd_read_path (
   input  wire logic                        i_ref_clk,     // 10 MHz clock
   input  wire logic                        i_rst_n,       // Sync reset, active low
   input  wire logic                        i_cycle_pulse, // One pulse per read cycle
   input  wire logic [11:0]                 i_addr,        // Word address from sequencer
   input  wire logic                        i_inhibit,     // Store inhibit
   input  wire logic [47:0]                 i_sense,       // Sense amplifier outputs
   output csd_pkg::csd_strobe_s             o_strobes,     // Internal strobes
   output logic      [31:0]                 o_gate_sel,    // Gate drive, one-hot
   output logic      [63:0]                 o_drv_sel,     // Driver drive, one-hot
   output logic      [7:0]                  o_drv_lo_oct,  // Low octal decoder lines
   output logic      [7:0]                  o_drv_hi_oct,  // High octal decoder lines
   output logic      [4:0]                  o_gate_num,    // Global gate number
   output logic      [2:0]                  o_module_num,  // Module number
   output logic      [1:0]                  o_local_gate,  // Gate within module
   output logic      [5:0]                  o_drv_num,     // Driver number
   output logic      [6:0]                  o_tape_num,    // Tape number
   output logic                             o_word_b,      // Second word of tape
   output logic      [47:0]                 o_word         // Sense latches
);

   csd_pkg::csd_addr_s             dec_ff;
   logic [csd_pkg::TAP_LEN-1:0]    tap_ff;
   logic [csd_pkg::TAP_LEN-1:0]    nxt_tap;
   logic [47:0]                    word_ff;
   logic [47:0]                    nxt_word;
   logic [6:0]                     tape_ff;
   logic [6:0]                     nxt_tape;

   wire        cycle_busy;
   wire        cycle_start;
   wire        gate_on;
   wire        drv_on;
   wire        sense_rst_pulse;
   wire        sense_stb_pulse;
   wire [5:0]  addr_drv;
   wire [31:0] gate_lines;
   wire [7:0]  lo_lines;
   wire [7:0]  hi_lines;

   assign cycle_busy  = |tap_ff[csd_pkg::TAP_SENSE:0];
   assign cycle_start = i_cycle_pulse & ~cycle_busy;
   assign nxt_tap     = {tap_ff[csd_pkg::TAP_LEN-2:0], cycle_start};

   assign gate_on = tap_ff[csd_pkg::TAP_GATE] | tap_ff[csd_pkg::TAP_DRIVE] | tap_ff[csd_pkg::TAP_SENSE];
   assign drv_on  = tap_ff[csd_pkg::TAP_DRIVE] | tap_ff[csd_pkg::TAP_SENSE];

   assign sense_rst_pulse = tap_ff[csd_pkg::TAP_RESTORE] & ~i_inhibit;
   assign sense_stb_pulse = tap_ff[csd_pkg::TAP_SENSE] & ~i_inhibit;

   assign nxt_word = sense_stb_pulse ? i_sense :
                     sense_rst_pulse ? csd_pkg::WORD_RST : word_ff;

   assign addr_drv = i_addr[csd_pkg::DRV_MSB:0];
   assign nxt_tape = i_addr[csd_pkg::UPPER_HALF_BIT] ? (csd_pkg::TAPE_MAX - {1'b0, addr_drv})
                                                     : {1'b0, addr_drv};

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         tap_ff  <= '0;
         dec_ff  <= '0;
         tape_ff <= '0;
         word_ff <= csd_pkg::WORD_RST;
      end
      else
      begin
         tap_ff  <= nxt_tap;
         word_ff <= nxt_word;
         if (cycle_start)
         begin
            dec_ff  <= i_addr;
            tape_ff <= nxt_tape;
         end
      end
   end

   assign o_gate_num   = {dec_ff.module_num, dec_ff.local_gate};
   assign o_module_num = dec_ff.module_num;
   assign o_local_gate = dec_ff.local_gate;
   assign o_drv_num    = {dec_ff.drv_hi, dec_ff.drv_lo};
   assign o_tape_num   = tape_ff;
   // Odd local gate is B word
   assign o_word_b     = dec_ff.local_gate[0];
   assign o_word       = word_ff;

   csd_onehot_dec #(
      .IN_W (5)
   ) u_gate_dec (
      .i_sel   (o_gate_num),
      .i_en    (gate_on),
      .o_lines (gate_lines)
   );

   csd_onehot_dec #(
      .IN_W (3)
   ) u_drv_lo_dec (
      .i_sel   (dec_ff.drv_lo),
      .i_en    (drv_on),
      .o_lines (lo_lines)
   );

   csd_onehot_dec #(
      .IN_W (3)
   ) u_drv_hi_dec (
      .i_sel   (dec_ff.drv_hi),
      .i_en    (drv_on),
      .o_lines (hi_lines)
   );

   assign o_gate_sel   = gate_lines;
   assign o_drv_lo_oct = lo_lines;
   assign o_drv_hi_oct = hi_lines;

   genvar gh;
   generate
      for (gh = 0; gh < csd_pkg::OCTAL_LINES; gh++)
      begin : g_drv_row
         assign o_drv_sel[gh*8 +: 8] = lo_lines & {8{hi_lines[gh]}};
      end
   endgenerate

   assign o_strobes.sense_restore = tap_ff[csd_pkg::TAP_RESTORE];
   assign o_strobes.gate_strobe   = tap_ff[csd_pkg::TAP_GATE];
   assign o_strobes.drv_supply    = gate_on;
   assign o_strobes.drv_strobe    = tap_ff[csd_pkg::TAP_DRIVE];
   assign o_strobes.array_current = drv_on;
   assign o_strobes.sense_reset   = sense_rst_pulse;
   assign o_strobes.sense_strobe  = sense_stb_pulse;

   // Assertions

   property p_gate_field;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      cycle_start |=> (o_gate_num == $past(i_addr[csd_pkg::GATE_NUM_MSB:csd_pkg::GATE_LSB]));
   endproperty
   a_gate_field: assert property (p_gate_field) else $error("gate number not from address 10-6");

   property p_module_gate;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      cycle_start |=> (o_module_num == $past(i_addr[csd_pkg::MODULE_MSB:csd_pkg::MODULE_LSB]))
                      && ({o_module_num, 2'b00} + {3'b000, o_local_gate} == o_gate_num);
   endproperty
   a_module_gate: assert property (p_module_gate) else $error("module and local gate mismatch");

   property p_drv_field;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      cycle_start |=> (o_drv_num == $past(i_addr[csd_pkg::DRV_MSB:0]));
   endproperty
   a_drv_field: assert property (p_drv_field) else $error("driver number not from address 5-0");

   property p_drv_matrix;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      o_strobes.array_current |-> o_drv_sel[o_drv_num] && o_drv_lo_oct[o_drv_num[2:0]]
                                  && o_drv_hi_oct[o_drv_num[5:3]];
   endproperty
   a_drv_matrix: assert property (p_drv_matrix) else $error("driver lines do not meet at driver");

   property p_tape;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      cycle_start |=> (o_tape_num == ($past(i_addr[csd_pkg::UPPER_HALF_BIT])
                                      ? 7'h7f - {1'b0, $past(i_addr[5:0])}
                                      : {1'b0, $past(i_addr[5:0])}));
   endproperty
   a_tape: assert property (p_tape) else $error("tape number wrong");

   property p_word_half;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      cycle_start |=> (o_word_b == $past(i_addr[csd_pkg::WORD_HALF_BIT]));
   endproperty
   a_word_half: assert property (p_word_half) else $error("word half not from bit 6");

   property p_sequence;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      cycle_start |=> o_strobes.sense_restore ##1 o_strobes.gate_strobe ##1 o_strobes.drv_strobe
                      ##1 (tap_ff[csd_pkg::TAP_SENSE] && o_strobes.array_current);
   endproperty
   a_sequence: assert property (p_sequence) else $error("strobe sequence broken");

   property p_restore_decode;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      o_strobes.sense_restore |-> !o_strobes.gate_strobe && (o_gate_sel == 32'h0) && (o_drv_sel == 64'h0);
   endproperty
   a_restore_decode: assert property (p_restore_decode) else $error("selection active during restore");

   property p_gate_first;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      $rose(o_strobes.gate_strobe) |-> (o_drv_sel == 64'h0) ##1 o_strobes.drv_strobe;
   endproperty
   a_gate_first: assert property (p_gate_first) else $error("driver not after gate");

   property p_supply_with_gate;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (o_gate_sel != 32'h0) |-> o_strobes.drv_supply && (o_gate_sel[o_gate_num]);
   endproperty
   a_supply_with_gate: assert property (p_supply_with_gate) else $error("supply not with gate");

   property p_sense_delay;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      o_strobes.sense_strobe |-> $past(o_strobes.array_current) && !$past(o_strobes.array_current, 2)
                                 ##1 (o_word == $past(i_sense));
   endproperty
   a_sense_delay: assert property (p_sense_delay) else $error("sense strobe timing or capture wrong");

   property p_supply_off;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      tap_ff[csd_pkg::TAP_SENSE] |=> !o_strobes.drv_supply && !o_strobes.array_current;
   endproperty
   a_supply_off: assert property (p_supply_off) else $error("supply still on after sense");

   property p_inhibit_hold;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      i_inhibit |-> !o_strobes.sense_reset && !o_strobes.sense_strobe ##1 (o_word == $past(o_word));
   endproperty
   a_inhibit_hold: assert property (p_inhibit_hold) else $error("latches changed under inhibit");

   property p_onehot_sel;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      o_strobes.array_current |-> $onehot(o_gate_sel) && $onehot(o_drv_sel);
   endproperty
   a_onehot_sel: assert property (p_onehot_sel) else $error("not one gate and one driver");

   property p_word_stable;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      !o_strobes.sense_reset && !o_strobes.sense_strobe |=> $stable(o_word);
   endproperty
   a_word_stable: assert property (p_word_stable) else $error("control word moved between strobes");

   property p_word_reset;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      o_strobes.sense_reset |=> (o_word == csd_pkg::WORD_RST);
   endproperty
   a_word_reset: assert property (p_word_reset) else $error("sense latches not cleared by sense reset");

   property p_supply_tap;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      tap_ff[csd_pkg::TAP_SUPPLY_OFF] |-> !o_strobes.drv_supply && !o_strobes.array_current && (o_drv_sel == 64'h0);
   endproperty
   a_supply_tap: assert property (p_supply_tap) else $error("supply on at the supply-off tap");

   property p_fields_hold;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      !cycle_start |=> $stable(o_gate_num) && $stable(o_drv_num) && $stable(o_tape_num) && $stable(o_word_b);
   endproperty
   a_fields_hold: assert property (p_fields_hold) else $error("address fields moved without a cycle start");

   property p_cycle_spacing;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      o_strobes.sense_restore |=> (!o_strobes.sense_restore) [*4];
   endproperty
   a_cycle_spacing: assert property (p_cycle_spacing) else $error("restore strobes closer than one cycle");

endmodule : csd_read_path

//--- tb/csd_seq_model.sv
/*
 * Sequencer stand-in: issues cycle pulses with word addresses and plays the sense amplifiers.
 * Assumes the bench changes i_go and i_go_addr just after the rising edge.
 */
`timescale 1ns/10ps

module csd_seq_model (
   input  wire logic        i_clk,     // Reference clock
   input  wire logic        i_go,      // Request a cycle
   input  wire logic [11:0] i_go_addr, // Address to issue
   output logic             o_pulse,   // Cycle pulse
   output logic      [11:0] o_addr,    // Word address
   output logic      [47:0] o_sense    // Sense outputs
);
   logic        g;
   logic [11:0] ga;
   logic [11:0] last;
   int          cnt;

   function automatic logic [47:0] pat(input logic [11:0] a);
      return {a, ~a, a, ~a};
   endfunction : pat

   initial
   begin
      o_pulse = 1'b0;
      o_addr  = 12'h000;
      o_sense = 48'h0;
      last    = 12'h000;
      cnt     = 15;
   end

   always @(posedge i_clk)
   begin
      g  = i_go;
      ga = i_go_addr;
      #1;
      o_pulse = g;
      // Address is only valid beside the pulse, so scramble it elsewhere
      o_addr  = g ? ga : ~o_addr;
      if (g && cnt >= 4)
      begin
         last = ga;
         cnt  = 0;
      end
      else if (cnt < 15)
         cnt = cnt + 1;
      // amplifiers settled only at the sense tap
      o_sense = (cnt == 4) ? pat(last) : ~pat(last);
   end
endmodule : csd_seq_model

//--- tb/test_csd_read_path.sv
/*
 * Self-checking bench for the control store read path.
 * Assumes the sequencer model drives pulse, address and sense lines.
 */
`timescale 1ns/10ps

module test_csd_read_path;
   logic                 i_ref_clk, i_rst_n, i_inhibit, go, i_cycle_pulse;
   logic [11:0]          i_addr, go_addr;
   logic [47:0]          i_sense, o_word, word_exp;
   csd_pkg::csd_strobe_s o_strobes;
   logic [31:0]          o_gate_sel;
   logic [63:0]          o_drv_sel;
   logic [7:0]           o_drv_lo_oct, o_drv_hi_oct;
   logic [4:0]           o_gate_num;
   logic [2:0]           o_module_num;
   logic [1:0]           o_local_gate;
   logic [5:0]           o_drv_num;
   logic [6:0]           o_tape_num;
   logic                 o_word_b;
   int                   errors, checks_done, ticks;
   // Rows: address, gate, driver, tape, second word
   logic [30:0] rows [6] = '{{12'h000, 5'h00, 6'h00, 7'h00, 1'h0}, {12'hfff, 5'h1f, 6'h3f, 7'h40, 1'h1},
                             {12'h650, 5'h19, 6'h10, 7'h10, 1'h1}, {12'h0a0, 5'h02, 6'h20, 7'h5f, 1'h0},
                             {12'h83f, 5'h00, 6'h3f, 7'h3f, 1'h0}, {12'h7c1, 5'h1f, 6'h01, 7'h7e, 1'h1}};
   logic [6:0]  stb [5] = '{7'h00, 7'h42, 7'h30, 7'h1c, 7'h15};

   csd_read_path dut_u (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_cycle_pulse(i_cycle_pulse),
      .i_addr(i_addr), .i_inhibit(i_inhibit), .i_sense(i_sense), .o_strobes(o_strobes),
      .o_gate_sel(o_gate_sel), .o_drv_sel(o_drv_sel), .o_drv_lo_oct(o_drv_lo_oct),
      .o_drv_hi_oct(o_drv_hi_oct), .o_gate_num(o_gate_num), .o_module_num(o_module_num),
      .o_local_gate(o_local_gate), .o_drv_num(o_drv_num), .o_tape_num(o_tape_num),
      .o_word_b(o_word_b), .o_word(o_word));

   csd_seq_model seq_u (.i_clk(i_ref_clk), .i_go(go), .i_go_addr(go_addr), .o_pulse(i_cycle_pulse),
      .o_addr(i_addr), .o_sense(i_sense));

   initial
   begin
      i_ref_clk = 1'b0;
      forever #50 i_ref_clk = ~i_ref_clk;
   end

   task automatic complete_run;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : complete_run

   always @(posedge i_ref_clk)
   begin
      ticks++;
      if (ticks == 3000)
      begin
         errors++;
         complete_run();
      end
   end

   task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic idle_chk();
      chk("idle strobes", o_strobes, 64'h0);
      chk("idle gates", o_gate_sel | o_drv_sel, 64'h0);
      chk("idle word", o_word, word_exp);
   endtask : idle_chk

   // Entered idle or in c4; leaves in c4, so chained calls run back to back
   task automatic run_cycle(input logic [30:0] r, input logic inh1, input logic inh4, input logic poke);
      logic [11:0] a;
      logic [4:0]  g;
      logic [5:0]  d;
      logic [6:0]  s;
      logic [47:0] mid;
      a   = r[30:19];
      g   = r[18:14];
      d   = r[13:8];
      mid = inh1 ? word_exp : 48'h0;
      go      = 1'b1;
      go_addr = a;
      @(posedge i_ref_clk);
      #1 go = 1'b0;
      // inhibit of c4 stays up through the capture edge
      i_inhibit = 1'b0;
      #40 idle_chk();
      for (int k = 1; k <= 4; k++)
      begin
         @(posedge i_ref_clk);
         #1 i_inhibit = (k == 1) ? inh1 : (k == 4) ? inh4 : 1'b0;
         go = poke && (k == 1);
         go_addr = ~a;
         #40;
         s = stb[k] & ~{5'h00, (k == 1) && inh1, (k == 4) && inh4};
         chk("strobes", o_strobes, s);
         chk("gate_sel", o_gate_sel, (k >= 2) ? 32'h1 << g : 32'h0);
         chk("drv_sel", o_drv_sel, (k >= 3) ? 64'h1 << d : 64'h0);
         chk("octal", {o_drv_hi_oct, o_drv_lo_oct}, (k >= 3) ? {8'h1 << d[5:3], 8'h1 << d[2:0]} : 16'h0);
         chk("fields", {o_gate_num, o_module_num, o_local_gate, o_drv_num, o_tape_num, o_word_b},
             {g, g[4:2], g[1:0], d, r[7:0]});
         chk("word", o_word, (k == 1) ? word_exp : mid);
      end
      word_exp = inh4 ? mid : {a, ~a, a, ~a};
   endtask : run_cycle

   initial
   begin
      i_rst_n   = 1'b0;
      i_inhibit = 1'b0;
      go        = 1'b0;
      go_addr   = 12'h000;
      word_exp  = 48'h0;
      repeat (10) @(posedge i_ref_clk);
      #1 i_rst_n = 1'b1;
      #40 idle_chk();
      foreach (rows[i])
         run_cycle(rows[i], 1'b0, 1'b0, 1'b0);
      run_cycle(rows[2], 1'b1, 1'b1, 1'b0);
      run_cycle(rows[3], 1'b1, 1'b0, 1'b0);
      run_cycle(rows[1], 1'b0, 1'b1, 1'b0);
      // Pulse in c2 must be refused while the taps are busy
      run_cycle(rows[5], 1'b0, 1'b0, 1'b1);
      run_cycle(rows[4], 1'b0, 1'b0, 1'b0);
      @(posedge i_ref_clk);
      #41 idle_chk();
      // Reset in mid-cycle clears every latch
      go = 1'b1;
      @(posedge i_ref_clk);
      #1 go = 1'b0;
      @(posedge i_ref_clk);
      #1 i_rst_n = 1'b0;
      @(posedge i_ref_clk);
      #1 i_rst_n = 1'b1;
      word_exp = 48'h0;
      repeat (5) @(posedge i_ref_clk);
      #41 idle_chk();
      chk("reset fields", {o_gate_num, o_module_num, o_local_gate, o_drv_num, o_tape_num, o_word_b}, 64'h0);
      run_cycle(rows[2], 1'b0, 1'b0, 1'b0);
      @(posedge i_ref_clk);
      #41 idle_chk();
      complete_run();
   end
endmodule : test_csd_read_path
